// ===== design/nvram_port_ctrl.sv
// Notes on behaviour
// - Write strobe high through every read.
// - Reads last 35 ns; data follows address.
// - Raised strobes stay high at least 2 ns.
// - Select falls spaced by at least 35 ns.
// - Write strobe low at least 15 ns.
// - Address set early, held 12 ns after write.
// - Write data valid 10 ns before write end.
// - Select low 15 ns, write cycle 35 ns.
// - Hold select and strobe high 2 ms after power.
module nvram_port_ctrl
   import nvram_port_pkg::*;
#(
   parameter int unsigned startup_count = startup_cycles
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [addr_width-1:0] req_addr,
   input wire logic [data_width-1:0] req_wdata,
   input wire logic [1:0] req_lanes,
   output logic rsp_valid,
   output logic [data_width-1:0] rsp_rdata,
   output logic [addr_width-1:0] mem_addr,
   output logic chip_sel_n,
   output logic write_n,
   output logic out_en_n,
   output logic low_lane_sel_n,
   output logic high_lane_sel_n,
   input wire logic [7:0] low_lane_bus_i,
   output logic [7:0] low_lane_bus_o,
   output logic low_lane_bus_oe,
   input wire logic [7:0] high_lane_bus_i,
   output logic [7:0] high_lane_bus_o,
   output logic high_lane_bus_oe
);
   state_type state_q;
   state_type state_d;
   // The boot counter spans the full startup time at the real clock rate.
   logic [21:0] boot_q;
   logic [21:0] boot_d;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [addr_width-1:0] addr_q;
   logic [addr_width-1:0] addr_d;
   logic [data_width-1:0] wdata_q;
   logic [data_width-1:0] wdata_d;
   logic [data_width-1:0] rdata_q;
   logic [data_width-1:0] rdata_d;
   logic [1:0] lanes_q;
   logic [1:0] lanes_d;
   logic ce_q;
   logic ce_d;
   logic we_q;
   logic we_d;
   logic oe_q;
   logic oe_d;
   logic drv_q;
   logic drv_d;
   logic rsp_q;
   logic rsp_d;

   // Every cnt_q countdown ends on the same value, so one test serves the read, read gap, write and recovery states.
   function automatic logic count_done(input logic [7:0] c);
      return c == cnt_one;
   endfunction : count_done

   // A lane is selected only while the cycle holds chip select low.
   function automatic logic lane_sel_n(input logic ce, input logic en);
      return ~(ce & en);
   endfunction : lane_sel_n

   // Outputs default to idle so that every path leaves the strobes high.
   always_comb begin
      state_d = state_q;
      boot_d = boot_q;
      cnt_d = (cnt_q == 8'h00) ? 8'h00 : cnt_q - cnt_one;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      lanes_d = lanes_q;
      ce_d = 1'b0;
      we_d = 1'b0;
      oe_d = 1'b0;
      drv_d = 1'b0;
      rsp_d = 1'b0;
      case (state_q)
         st_boot: begin
            // Select and strobe stay high until the memory supply has settled.
            if (boot_q == 22'h000000) begin
               state_d = st_idle;
            end else begin
               boot_d = boot_q - 22'h000001;
            end
         end
         st_idle: begin
            if (req_valid) begin
               addr_d = req_addr;
               wdata_d = req_wdata;
               lanes_d = req_lanes;
               ce_d = 1'b1;
               if (req_write) begin
                  // Address and data are set up with the select fall.
                  we_d = 1'b1;
                  drv_d = 1'b1;
                  cnt_d = 8'(write_low_cycles);
                  state_d = st_write;
               end else begin
                  oe_d = 1'b1;
                  cnt_d = 8'(read_access_cycles);
                  state_d = st_read;
               end
            end
         end
         st_read: begin
            ce_d = 1'b1;
            oe_d = 1'b1;
            if (count_done(cnt_q)) begin
               // Both lanes are captured; an unselected lane is left to the requester.
               rdata_d = {high_lane_bus_i, low_lane_bus_i};
               rsp_d = 1'b1;
               ce_d = 1'b0;
               oe_d = 1'b0;
               // The device may drive for up to 15 ns after release.
               cnt_d = 8'(float_cycles);
               state_d = st_rgap;
            end
         end
         st_rgap: begin
            // The gap lets the memory float the bus before the next cycle may drive it.
            if (count_done(cnt_q)) begin
               state_d = st_idle;
            end
         end
         st_write: begin
            ce_d = 1'b1;
            we_d = 1'b1;
            drv_d = 1'b1;
            if (count_done(cnt_q)) begin
               ce_d = 1'b0;
               we_d = 1'b0;
               // Data is held one more cycle past the terminating edge.
               drv_d = 1'b1;
               cnt_d = 8'(recovery_cycles);
               state_d = st_wrec;
            end
         end
         st_wrec: begin
            if (count_done(cnt_q)) begin
               state_d = st_gap;
            end
         end
         st_gap: begin
            // One spare cycle keeps select falls well past the minimum spacing.
            state_d = st_idle;
         end
         default: begin
            state_d = st_idle;
         end
      endcase
   end

   // Reset leaves every strobe high so the memory sees no cycle while in reset.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= st_boot;
         boot_q <= 22'(startup_count);
         cnt_q <= 8'h00;
         addr_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         lanes_q <= 2'h0;
         ce_q <= 1'b0;
         we_q <= 1'b0;
         oe_q <= 1'b0;
         drv_q <= 1'b0;
         rsp_q <= 1'b0;
      end else begin
         state_q <= state_d;
         boot_q <= boot_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         lanes_q <= lanes_d;
         ce_q <= ce_d;
         we_q <= we_d;
         oe_q <= oe_d;
         drv_q <= drv_d;
         rsp_q <= rsp_d;
      end
   end

   // Lane selects are asserted only while the cycle runs.
   // Ready is combinational so a request is taken on the first idle edge.
   assign req_ready = (state_q == st_idle);
   assign rsp_valid = rsp_q;
   assign rsp_rdata = rdata_q;
   assign mem_addr = addr_q;
   assign chip_sel_n = ~ce_q;
   assign write_n = ~we_q;
   assign out_en_n = ~oe_q;
   assign low_lane_sel_n = lane_sel_n(ce_q, lanes_q[0]);
   assign high_lane_sel_n = lane_sel_n(ce_q, lanes_q[1]);
   assign low_lane_bus_o = wdata_q[7:0];
   assign high_lane_bus_o = wdata_q[15:8];
   assign low_lane_bus_oe = drv_q;
   assign high_lane_bus_oe = drv_q;
endmodule : nvram_port_ctrl

// ===== design/nvram_port_pkg.sv
package nvram_port_pkg;
   localparam int unsigned clk_period_ns = 8;
   localparam int unsigned addr_width = 17;
   localparam int unsigned data_width = 16;
   // Times in ns as printed.
   localparam int unsigned min_cycle_time_ns = 35;
   localparam int unsigned addr_to_data_delay_ns = 35;
   localparam int unsigned select_to_data_delay_ns = 35;
   localparam int unsigned oe_to_data_delay_ns = 15;
   localparam int unsigned lane_to_data_delay_ns = 15;
   localparam int unsigned select_high_to_float_ns = 15;
   localparam int unsigned oe_high_to_float_ns = 10;
   localparam int unsigned strobe_high_hold_ns = 2;
   localparam int unsigned write_pulse_ns = 15;
   localparam int unsigned addr_to_write_end_oe_low_ns = 20;
   localparam int unsigned data_setup_ns = 10;
   localparam int unsigned write_recovery_ns = 12;
   localparam int unsigned strobe_high_to_drive_ns = 3;
   localparam int unsigned startup_time_ns = 2000000;
   // Cycle counts: least times rounded up, never below one cycle.
   function automatic int unsigned cycles_up(input int unsigned t_ns);
      int unsigned c;
      c = (t_ns + clk_period_ns - 1) / clk_period_ns;
      return (c < 1) ? 1 : c;
   endfunction : cycles_up
   localparam int unsigned cycle_cycles = cycles_up(min_cycle_time_ns);
   localparam int unsigned read_access_cycles = cycles_up(addr_to_data_delay_ns) + 1;
   localparam int unsigned float_cycles = cycles_up(select_high_to_float_ns);
   localparam int unsigned write_low_cycles = cycles_up(addr_to_write_end_oe_low_ns);
   localparam int unsigned recovery_cycles = cycles_up(write_recovery_ns);
   localparam int unsigned startup_cycles = cycles_up(startup_time_ns);
   localparam logic [7:0] cnt_one = 8'h01;
   typedef enum logic [2:0] {
      st_boot = 3'b000,
      st_idle = 3'b001,
      st_read = 3'b011,
      st_rgap = 3'b010,
      st_write = 3'b110,
      st_wrec = 3'b111,
      st_gap = 3'b101
   } state_type;
endpackage : nvram_port_pkg

// ===== verification/nvram_port_assertions.sv
module nvram_port_assertions
   import nvram_port_pkg::*;
#(
   parameter int unsigned startup_count = 10
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [addr_width-1:0] mem_addr,
   input wire logic chip_sel_n,
   input wire logic write_n,
   input wire logic out_en_n,
   input wire logic low_lane_bus_oe
);
   logic [31:0] up_q;
   logic [31:0] up_d;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence addr_held;
      $stable(mem_addr) ##1 $stable(mem_addr);
   endsequence : addr_held
   // The count saturates so that a long run cannot wrap it.
   always_comb up_d = (up_q > startup_count) ? up_q : up_q + 32'h1;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         up_q <= 32'h0;
      end else begin
         up_q <= up_d;
      end
   end
   a_boot_quiet: assert property (up_q <= startup_count |-> chip_sel_n && write_n)
      else $error("strobe in boot");
   a_read_no_write: assert property (!out_en_n |-> write_n)
      else $error("strobe in read");
   a_high_hold: assert property ($rose(write_n) |=> write_n)
      else $error("short high");
   a_select_hold: assert property ($rose(chip_sel_n) |=> chip_sel_n)
      else $error("short select high");
   a_select_gap: assert property ($fell(chip_sel_n) |=> (!$fell(chip_sel_n))[*4])
      else $error("select gap");
   a_pulse_len: assert property ($fell(write_n) |-> (!write_n)[*2])
      else $error("short write");
   a_select_len: assert property ($fell(chip_sel_n) |-> (!chip_sel_n)[*2])
      else $error("short select");
   a_addr_hold: assert property ($rose(write_n) |-> addr_held)
      else $error("address moved");
   a_data_setup: assert property ($rose(write_n) |-> $past(low_lane_bus_oe, 2))
      else $error("late data");
endmodule : nvram_port_assertions

// ===== verification/nvram_model.sv
module nvram_model
   import nvram_port_pkg::*;
(
   input wire logic [addr_width-1:0] mem_addr,
   input wire logic chip_sel_n,
   input wire logic write_n,
   input wire logic out_en_n,
   input wire logic [1:0] sel_n,
   input wire logic [15:0] wd,
   input wire logic [1:0] w_oe,
   input wire logic [5:0] dly,
   output logic [15:0] bus
);
   timeunit 1ns / 1ps;
   logic [15:0] mem [256];
   logic [15:0] rd;
   logic [1:0] drv;
   logic ok;
   int unsigned gen = 0;
   int unsigned gen_d;
   assign rd = mem[mem_addr[7:0]];
   assign drv = ~sel_n & {2{!chip_sel_n && !out_en_n && write_n}};
   // Lanes show inverted data when not driven, so an early sample is caught.
   assign bus[7:0] = w_oe[0] ? wd[7:0] : (drv[0] && ok) ? rd[7:0] : ~rd[7:0];
   assign bus[15:8] = w_oe[1] ? wd[15:8] : (drv[1] && ok) ? rd[15:8] : ~rd[15:8];
   // A change restarts the settle time, so a stale earlier change cannot mark data valid.
   assign #(dly) gen_d = gen;
   assign ok = (gen_d == gen);
   always @(mem_addr or chip_sel_n or out_en_n or sel_n) begin
      gen++;
   end
   // Supply is always valid here, so no write is ever inhibited.
   always @* begin
      if (!chip_sel_n && !write_n) begin
         if (!sel_n[0]) mem[mem_addr[7:0]][7:0] = wd[7:0];
         if (!sel_n[1]) mem[mem_addr[7:0]][15:8] = wd[15:8];
      end
   end
endmodule : nvram_model

// ===== verification/testbench.sv
module testbench;
   timeunit 1ns / 1ps;
   import nvram_port_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [16:0] req_addr = 17'h0;
   logic [15:0] req_wdata = 16'h0;
   logic [1:0] req_lanes = 2'h0;
   logic [5:0] dly = 6'h23;
   logic req_ready, rsp_valid, chip_sel_n, write_n, out_en_n;
   logic low_lane_sel_n, high_lane_sel_n, low_lane_bus_oe, high_lane_bus_oe;
   logic [15:0] rsp_rdata, q;
   logic [16:0] mem_addr;
   logic [7:0] low_lane_bus_o, high_lane_bus_o;
   wire [7:0] low_lane_bus_i, high_lane_bus_i;
   int num_errors = 0;
   int checked = 0;
   int cyc = 0;
   nvram_port_ctrl #(.startup_count(10)) nvram_port_ctrl_inst (.mclk, .rst_b, .req_valid,
      .req_ready, .req_write, .req_addr, .req_wdata, .req_lanes, .rsp_valid, .rsp_rdata,
      .mem_addr, .chip_sel_n, .write_n, .out_en_n, .low_lane_sel_n, .high_lane_sel_n,
      .low_lane_bus_i, .low_lane_bus_o, .low_lane_bus_oe, .high_lane_bus_i,
      .high_lane_bus_o, .high_lane_bus_oe);
   nvram_model nvram_model_inst (.mem_addr, .chip_sel_n, .write_n, .out_en_n, .dly,
      .sel_n({high_lane_sel_n, low_lane_sel_n}), .wd({high_lane_bus_o, low_lane_bus_o}),
      .w_oe({high_lane_bus_oe, low_lane_bus_oe}), .bus({high_lane_bus_i, low_lane_bus_i}));
   initial forever #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : cmp
   task automatic op(input logic w, input logic [16:0] a, input logic [15:0] d,
      input logic [1:0] l);
      while (req_ready !== 1'b1) @(negedge mclk);
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_lanes = l;
      @(negedge mclk);
      req_valid = 1'b0;
      while (!w && rsp_valid !== 1'b1) @(negedge mclk);
      q = rsp_rdata;
   endtask : op
   task automatic t_word;
      op(1'b1, 17'h100aa, 16'h0f0f, 2'h3);
      op(1'b1, 17'h000ab, 16'hf0f0, 2'h3);
      op(1'b0, 17'h100aa, 16'h0, 2'h3);
      cmp(q, 16'h0f0f);
      op(1'b0, 17'h000ab, 16'h0, 2'h3);
      cmp(q, 16'hf0f0);
   endtask : t_word
   task automatic t_lane;
      dly = 6'h4;
      op(1'b1, 17'h100aa, 16'h1e77, 2'h1);
      op(1'b0, 17'h100aa, 16'h0, 2'h3);
      cmp(q, 16'h0f77);
      op(1'b0, 17'h000ab, 16'h0, 2'h2);
      cmp({q[15:8], 8'h0}, 16'hf000);
   endtask : t_lane
   initial begin
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      cmp({13'h0, chip_sel_n, write_n, req_ready}, 16'h6);
      t_word();
      t_lane();
      end_sim();
   end
endmodule : testbench
bind nvram_port_ctrl nvram_port_assertions #(.startup_count(startup_count)) chk (.mclk,
   .rst_b, .mem_addr, .chip_sel_n, .write_n, .out_en_n, .low_lane_bus_oe);
